// *** src/ies_pkg.sv ***
// Package for the interrupt event status block: offsets, bit positions,
// reset values and the carrier structs shared by the design.
// Assumes a 32-bit APB register bus with an 8-bit byte address.
package ies_pkg;

    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_COMMAND = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h14;

    // Status bit positions
    localparam int BIT_TX_RESET_DONE = 25;
    localparam int BIT_RX_RESET_DONE = 24;
    localparam int BIT_PARITY_ERR = 23;
    localparam int BIT_SYS_ERR = 22;
    localparam int BIT_MASTER_ABORT = 21;
    localparam int BIT_TARGET_ABORT = 20;
    localparam int BIT_RX_STAT_OVF = 16;
    localparam int BIT_SUMMARY = 15;
    localparam int BIT_PHY = 14;
    localparam int BIT_WAKE = 13;
    localparam int BIT_SOFTWARE = 12;
    localparam int BIT_MIB = 11;
    localparam int BIT_TX_UNDERFLOW = 10;
    localparam int BIT_TX_IDLE = 9;
    localparam int BIT_TX_FAILED = 8;
    localparam int BIT_UPPER_HI = 25;
    localparam int BIT_UPPER_LO = 16;

    // Command register: software interrupt request bit
    localparam int BIT_CMD_SWI = 7;

    // Bits that can hold a flag; all others except the derived summary bit read zero
    localparam logic [31:0] FLAG_MASK = 32'h03F1_7F00;
    // Mask bits that exist: every flag plus the summary bit
    localparam logic [31:0] MASK_BITS = 32'h03F1_FF00;
    localparam logic [31:0] STATUS_RST = 32'h0300_8000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // Event inputs from the surrounding controller, same clock
    typedef struct packed {
        logic tx_reset_done;
        logic rx_reset_done;
        logic cfg_parity_err;
        logic sys_err;
        logic master_abort;
        logic target_abort;
        logic rx_stat_ovf;
        logic phy_irq;
        logic wake_detect;
        logic mib_thresh;
        logic tx_underflow;
        logic tx_idle;
        logic tx_failed;
    } ies_events_t;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } ies_apb_req_t;

endpackage

// *** src/ies_status.sv ***
// Interrupt event status register with mask and command register,
// reached over APB; drives the open-drain PCI interrupt pin.
// Events come from logic on the same clock; soft reset is a pulse.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps

module ies_status
    import ies_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_soft_rst,
    input wire ies_apb_req_t i_apb,
    input wire ies_events_t i_evt,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    output logic o_inta_out,
    output logic o_inta_oe
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [31:0] status;
        logic [31:0] mask;
        logic cmd_swi;
        logic tx_idle_prev;
        logic [31:0] rdata;
        logic irq;
    } ies_state_t;

    localparam ies_state_t STATE_RST = '{
        status: STATUS_RST & FLAG_MASK,
        mask: MASK_RST,
        cmd_swi: 1'b0,
        tx_idle_prev: 1'b1,
        rdata: ZERO_WORD,
        irq: 1'b0
    };

    ies_state_t state_reg;
    ies_state_t state_next;

    logic setup_ph;
    logic access_ph;
    logic hit_cmd;
    logic hit_status;
    logic hit_mask;
    logic [31:0] set_vec;
    logic [31:0] status_view;
    logic [31:0] read_view;
    logic [31:0] next_view;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign setup_ph = i_apb.psel && !i_apb.penable;
    assign access_ph = i_apb.psel && i_apb.penable;
    assign hit_cmd = i_apb.paddr == ADDR_COMMAND;
    assign hit_status = i_apb.paddr == ADDR_STATUS;
    assign hit_mask = i_apb.paddr == ADDR_MASK;

    // Zero wait states; unmapped addresses answer with an error
    assign o_pready = 1'b1;
    assign o_pslverr = access_ph && !(hit_cmd || hit_status || hit_mask);

    ////////////////////////////////////////////////////////////////////////
    // Event collection

    always_comb begin
        set_vec = ZERO_WORD;
        set_vec[BIT_TX_RESET_DONE] = i_evt.tx_reset_done;
        set_vec[BIT_RX_RESET_DONE] = i_evt.rx_reset_done;
        set_vec[BIT_PARITY_ERR] = i_evt.cfg_parity_err;
        set_vec[BIT_SYS_ERR] = i_evt.sys_err;
        set_vec[BIT_MASTER_ABORT] = i_evt.master_abort;
        set_vec[BIT_TARGET_ABORT] = i_evt.target_abort;
        set_vec[BIT_RX_STAT_OVF] = i_evt.rx_stat_ovf;
        set_vec[BIT_PHY] = i_evt.phy_irq;
        set_vec[BIT_WAKE] = i_evt.wake_detect;
        set_vec[BIT_SOFTWARE] = state_reg.cmd_swi;
        set_vec[BIT_MIB] = i_evt.mib_thresh;
        set_vec[BIT_TX_UNDERFLOW] = i_evt.tx_underflow;
        // Busy to idle transition only
        set_vec[BIT_TX_IDLE] = i_evt.tx_idle
            && !state_reg.tx_idle_prev;
        set_vec[BIT_TX_FAILED] = i_evt.tx_failed;
    end

    // Summary bit is derived, never stored
    always_comb begin
        status_view = state_reg.status & FLAG_MASK;
        status_view[BIT_SUMMARY] =
            |state_reg.status[BIT_UPPER_HI:BIT_UPPER_LO];
    end

    always_comb begin
        read_view = ZERO_WORD;
        if (hit_status) begin
            read_view = status_view;
        end else if (hit_mask) begin
            read_view = state_reg.mask;
        end else if (hit_cmd) begin
            read_view[BIT_CMD_SWI] = state_reg.cmd_swi;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_next = state_reg;
        state_next.tx_idle_prev = i_evt.tx_idle;
        // Read data sampled in setup; only those bits are cleared later
        if (setup_ph && !i_apb.pwrite) begin
            state_next.rdata = read_view;
        end
        if (access_ph && !i_apb.pwrite && hit_status) begin
            state_next.status = state_reg.status
                & ~state_reg.rdata;
        end
        if (access_ph && i_apb.pwrite && hit_mask) begin
            state_next.mask = i_apb.pwdata & MASK_BITS;
        end
        if (access_ph && i_apb.pwrite && hit_cmd) begin
            state_next.cmd_swi = i_apb.pwdata[BIT_CMD_SWI];
        end
        // Writes to status fall through untouched; set wins over clear
        state_next.status = (state_next.status | set_vec)
            & FLAG_MASK;
        if (i_soft_rst) begin
            state_next = STATE_RST;
            // Keep tracking the line so a later rise is still seen
            state_next.tx_idle_prev = i_evt.tx_idle;
        end
        next_view = state_next.status & FLAG_MASK;
        next_view[BIT_SUMMARY] =
            |state_next.status[BIT_UPPER_HI:BIT_UPPER_LO];
        state_next.irq = |(next_view & state_next.mask);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_prdata = state_reg.rdata;
    // Open drain: pin is only ever pulled low
    assign o_inta_out = 1'b0;
    assign o_inta_oe = state_reg.irq;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_status_read;
        access_ph && !i_apb.pwrite && hit_status;
    endsequence

    sequence s_status_write;
        access_ph && i_apb.pwrite && hit_status;
    endsequence

    sequence s_mask_write;
        access_ph && i_apb.pwrite && hit_mask;
    endsequence

    a_irq_follows_flags: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_inta_oe == |(status_view & state_reg.mask))
        else $error("Interrupt pin does not match masked flags");

    a_event_sets_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (set_vec != ZERO_WORD) && !i_soft_rst |=>
        ((state_reg.status & $past(set_vec)) == $past(set_vec)))
        else $error("Event did not set its flag");

    a_read_clears: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_status_read ##0 (set_vec == ZERO_WORD) && !i_soft_rst |=>
        ((state_reg.status & $past(state_reg.rdata)) == ZERO_WORD))
        else $error("Status read did not clear flags");

    a_write_ignored: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_status_write ##0 !i_soft_rst |=>
        state_reg.status ==
        (($past(state_reg.status) | $past(set_vec)) & FLAG_MASK))
        else $error("Status write changed a flag");

    a_summary_bit: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_status_read |->
        o_prdata[BIT_SUMMARY] ==
        |o_prdata[BIT_UPPER_HI:BIT_UPPER_LO])
        else $error("Summary bit is not the OR of upper flags");

    a_tx_idle_edge: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(i_evt.tx_idle) && $past(i_rst_n) && !i_soft_rst |=>
        state_reg.status[BIT_TX_IDLE])
        else $error("Transmit idle transition not flagged");

    a_swi_sets: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        state_reg.cmd_swi && !i_soft_rst |=>
        state_reg.status[BIT_SOFTWARE])
        else $error("Software request did not set its flag");

    a_reserved_zero: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        ((state_reg.status & ~FLAG_MASK) |
        (state_reg.mask & ~MASK_BITS)) == ZERO_WORD)
        else $error("Reserved bit is set");

    a_soft_rst_mask: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_soft_rst |=> state_reg.mask == MASK_RST && !o_inta_oe)
        else $error("Soft reset left mask bits set");

    a_mask_written: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_mask_write ##0 !i_soft_rst |=>
        state_reg.mask == ($past(i_apb.pwdata) & MASK_BITS))
        else $error("Mask write not stored");

    a_tx_reset_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_evt.tx_reset_done && !i_soft_rst |=>
        state_reg.status[BIT_TX_RESET_DONE])
        else $error("Transmit reset done not flagged");

    a_rx_reset_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_evt.rx_reset_done && !i_soft_rst |=>
        state_reg.status[BIT_RX_RESET_DONE])
        else $error("Receive reset done not flagged");

    a_parity_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_evt.cfg_parity_err && !i_soft_rst |=>
        state_reg.status[BIT_PARITY_ERR])
        else $error("Parity error not flagged");

    a_sys_err_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_evt.sys_err && !i_soft_rst |=>
        state_reg.status[BIT_SYS_ERR])
        else $error("System error not flagged");

    a_master_abort_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_evt.master_abort && !i_soft_rst |=>
        state_reg.status[BIT_MASTER_ABORT])
        else $error("Master abort not flagged");

    a_target_abort_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_evt.target_abort && !i_soft_rst |=>
        state_reg.status[BIT_TARGET_ABORT])
        else $error("Target abort not flagged");

    a_rx_ovf_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_evt.rx_stat_ovf && !i_soft_rst |=>
        state_reg.status[BIT_RX_STAT_OVF])
        else $error("Receive status overflow not flagged");

    a_phy_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_evt.phy_irq && !i_soft_rst |=>
        state_reg.status[BIT_PHY])
        else $error("Physical layer request not flagged");

    a_wake_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_evt.wake_detect && !i_soft_rst |=>
        state_reg.status[BIT_WAKE])
        else $error("Wake condition not flagged");

    a_stats_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_evt.mib_thresh && !i_soft_rst |=>
        state_reg.status[BIT_MIB])
        else $error("Statistics threshold not flagged");

    a_underflow_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_evt.tx_underflow && !i_soft_rst |=>
        state_reg.status[BIT_TX_UNDERFLOW])
        else $error("Transmit underflow not flagged");

    a_tx_failed_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_evt.tx_failed && !i_soft_rst |=>
        state_reg.status[BIT_TX_FAILED])
        else $error("Transmit failure not flagged");

    a_flags_persist: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !(access_ph && !i_apb.pwrite && hit_status) && !i_soft_rst |=>
        ((state_reg.status & $past(state_reg.status)) ==
        $past(state_reg.status)))
        else $error("Flag cleared without a status read");

    a_read_returns_flags: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_status_read ##0 !$past(i_soft_rst) |->
        o_prdata == $past(status_view))
        else $error("Status read returned wrong flags");

    a_reserved_read: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_status_read |->
        (o_prdata & ~MASK_BITS) == ZERO_WORD)
        else $error("Reserved status bit read as one");

endmodule

// *** testbench/ies_evt_model.sv ***
// Event source standing for the controller logic around the status block.
// Assumes the bench asks for events with one request bit per event.
`timescale 1ns/10ps

module ies_evt_model
    import ies_pkg::*;
(
    input wire logic i_clk,
    input wire logic [12:0] i_fire,
    output ies_events_t o_evt
);
    // Each requested event follows its request bit one cycle later, high for as long as it is requested
    always_ff @(posedge i_clk) begin
        o_evt <= ies_events_t'(i_fire);
    end
endmodule

// *** testbench/interrupt_status_upper_bits_bench.sv ***
// Self-checking bench for the interrupt event status block.
// Assumes one clock; the master waits for pready however long it takes.
`timescale 1ns/10ps

module interrupt_status_upper_bits_bench;
    import ies_pkg::*;

    logic i_clk;
    logic rst_n;
    logic soft_rst;
    ies_apb_req_t apb_req;
    ies_events_t evt;
    logic [12:0] fire;
    logic pready, pslverr, inta_out, inta_oe;
    logic [31:0] prdata, rd, exp;
    logic err;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    int pos [13] = '{25, 24, 23, 22, 21, 20, 16, 14, 13, 11, 10, 9, 8};

    ies_evt_model model (.i_clk(i_clk), .i_fire(fire), .o_evt(evt));

    ies_status DUT (
        .i_clk(i_clk), .i_rst_n(rst_n), .i_soft_rst(soft_rst),
        .i_apb(apb_req), .i_evt(evt), .o_pready(pready),
        .o_pslverr(pslverr), .o_prdata(prdata),
        .o_inta_out(inta_out), .o_inta_oe(inta_oe)
    );

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] r, output logic e);
        logic rdy;
        @(posedge i_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
            pwdata: wd};
        @(posedge i_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge i_clk);
            rdy = pready;
            r = prdata;
            e = pslverr;
        end while (rdy !== 1'b1);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] want);
        apb(1'b0, a, ZERO_WORD, rd, err);
        check(rd, want);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic fire_evt(input logic [12:0] f);
        @(posedge i_clk);
        fire <= f;
        @(posedge i_clk);
        fire <= '0;
        repeat (2) @(posedge i_clk);
    endtask

    task automatic chk_oe(input logic want);
        @(negedge i_clk);
        check({31'h0000_0000, inta_oe}, {31'h0000_0000, want});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        apb_req = '0;
        fire = '0;
        soft_rst = 1'b0;
        rst_n = 1'b0;
        repeat (10) @(posedge i_clk);
        rst_n <= 1'b1;
        rd_reg(ADDR_STATUS, STATUS_RST);
        rd_reg(ADDR_STATUS, ZERO_WORD);
        rd_reg(ADDR_MASK, MASK_RST);
        for (int i = 0; i < 13; i++) begin
            fire_evt(13'h0001 << (12 - i));
            chk_oe(1'b0);
            exp = 32'h0000_0001 << pos[i];
            exp = exp | ((pos[i] >= 16) ? 32'h0000_8000 : ZERO_WORD);
            rd_reg(ADDR_STATUS, exp);
        end
        check({31'h0000_0000, inta_out}, ZERO_WORD);
        fire_evt(13'h0001);
        wr_reg(ADDR_STATUS, 32'hFFFF_FFFF);
        rd_reg(ADDR_STATUS, 32'h0000_0100);
        wr_reg(ADDR_MASK, 32'hFFFF_FFFF);
        rd_reg(ADDR_MASK, MASK_BITS);
        wr_reg(ADDR_MASK, 32'h0000_0100);
        fire_evt(13'h0002);
        chk_oe(1'b0);
        rd_reg(ADDR_STATUS, 32'h0000_0200);
        fire_evt(13'h0001);
        chk_oe(1'b1);
        rd_reg(ADDR_STATUS, 32'h0000_0100);
        chk_oe(1'b0);
        wr_reg(ADDR_COMMAND, 32'h0000_0080);
        rd_reg(ADDR_STATUS, 32'h0000_1000);
        rd_reg(ADDR_STATUS, 32'h0000_1000);
        wr_reg(ADDR_COMMAND, ZERO_WORD);
        wr_reg(ADDR_STATUS, ZERO_WORD);
        rd_reg(ADDR_STATUS, 32'h0000_1000);
        rd_reg(ADDR_STATUS, ZERO_WORD);
        apb(1'b0, 8'h20, ZERO_WORD, rd, err);
        check(rd, ZERO_WORD);
        check({31'h0000_0000, err}, 32'h0000_0001);
        wr_reg(ADDR_MASK, 32'h0000_8000);
        fire_evt(13'h0080);
        chk_oe(1'b1);
        @(posedge i_clk);
        soft_rst <= 1'b1;
        @(posedge i_clk);
        soft_rst <= 1'b0;
        chk_oe(1'b0);
        rd_reg(ADDR_STATUS, STATUS_RST);
        rd_reg(ADDR_MASK, MASK_RST);
        final_report();
    end
endmodule
